// >>> src/apc_pkg.sv
package apc_pkg;

  // ==================================================
  // Register map
  localparam logic [31:0] APC_COUNTER_BASE = 32'h0000_00c1;
  localparam logic [31:0] APC_SELECTOR_BASE = 32'h0000_0186;
  localparam logic [31:0] APC_SELECTOR_RESET = 32'h0000_0000;

  // ==================================================
  // Selector field positions
  localparam int APC_EVSEL_LSB = 0;
  localparam int APC_QUAL_LSB = 8;
  localparam int APC_USER_BIT = 16;
  localparam int APC_KERNEL_BIT = 17;
  localparam int APC_EDGE_BIT = 18;
  localparam int APC_PIN_BIT = 19;
  localparam int APC_INT_BIT = 20;
  localparam int APC_LATE_BIT = 21;
  localparam int APC_ENABLE_BIT = 22;
  localparam int APC_INV_BIT = 23;
  localparam int APC_THRESH_LSB = 24;

  // ==================================================
  // Event codes and qualifiers
  localparam logic [7:0] APC_EV_CORE_CYCLES = 8'h3c;
  localparam logic [7:0] APC_EV_INSTR_RETIRED = 8'hc0;
  localparam logic [7:0] APC_EV_BRANCH_RETIRED = 8'hc4;
  localparam logic [7:0] APC_EV_BRANCH_MISS = 8'hc5;
  localparam logic [7:0] APC_QUAL_DEFAULT = 8'h00;

  // ==================================================
  // Capability values
  localparam logic [7:0] APC_VERSION = 8'h01;
  localparam logic [7:0] APC_NUM_ARCH_EVENTS = 8'h07;
  localparam logic [31:0] APC_UNAVAIL_MASK = 32'h0000_009c;

  // ==================================================
  // Timing: monitor pin pulse lasts one bus clock
  localparam int APC_BUS_DIV = 4;

  // Register access request from the core
  typedef struct packed {
    logic rd;
    logic wr;
    logic [31:0] addr;
    logic [63:0] wdata;
  } apc_req_type;

  // Per-cycle event sources from the pipeline
  typedef struct packed {
    logic [2:0] instr_count;
    logic [2:0] branch_count;
    logic [2:0] miss_count;
    logic sleep;
    logic halt;
    logic thermal_throttle;
    logic freq_switch;
  } apc_event_type;

endpackage

// >>> src/apc_counters.sv
`timescale 1ns/1ps
module apc_counters #(
  parameter int NUM_CTR = 4,
  parameter int CTR_WIDTH = 48,
  parameter bit PIN_SUPPORTED = 1'b1,
  parameter int BUS_DIV = apc_pkg::APC_BUS_DIV
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Register access port
  input wire apc_pkg::apc_req_type req_i,
  output logic [63:0] rdata_o,
  output logic rvalid_o,
  output logic protection_fault_o,
  // Capability query
  input wire logic query_i,
  output logic [31:0] cap_eax_o,
  output logic [31:0] cap_ebx_o,
  // Processor state and events
  input wire logic [1:0] cpl_i,
  input wire apc_pkg::apc_event_type event_i,
  input wire logic stop_clock_pin_i,
  // Counter outputs
  output logic [NUM_CTR-1:0] monitor_pins_o,
  output logic [NUM_CTR-1:0] overflow_irq_o
);
  import apc_pkg::*;

  // Block overview:
  //   one selector and one counter per index, both private to this instance
  //   counting runs on the core clock, gated by the enable bit of each selector
  //   register port answers one cycle after the request, reads and faults alike
  //   monitor pins run on the slower bus tick, so a pulse spans BUS_DIV cycles
  //   capability words are loaded on a query and then hold

  // ==================================================
  // Pin synchroniser for the stop-clock input
  // The pin is asynchronous to the core clock; the first stage may go
  // metastable, so only the second and third stages are compared.
  logic stop_s1;
  logic stop_s2;
  logic stop_s3;
  logic stop_clock_active;

  // Three stages, change accepted when last two agree
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stop_s1 <= 1'b0;
      stop_s2 <= 1'b0;
      stop_s3 <= 1'b0;
      stop_clock_active <= 1'b0;
    end else begin
      stop_s1 <= stop_clock_pin_i;
      stop_s2 <= stop_s1;
      stop_s3 <= stop_s2;
      if (stop_s2 == stop_s3) begin
        stop_clock_active <= stop_s3;
      end
    end
  end

  // ==================================================
  // Bus clock enable divider
  // The monitor pins change only on this tick, so a pulse is one bus
  // period wide whatever the core clock does in between.
  // BUS_DIV must stay within the eight-bit counter range.
  logic [7:0] bus_cnt;
  logic bus_tick;

  // One-cycle enable every BUS_DIV system clocks
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_cnt <= 8'h00;
      bus_tick <= 1'b0;
    end else if (bus_cnt == 8'(BUS_DIV - 1)) begin
      bus_cnt <= 8'h00;
      bus_tick <= 1'b1;
    end else begin
      bus_cnt <= bus_cnt + 8'h01;
      bus_tick <= 1'b0;
    end
  end

  // ==================================================
  // Shared decode and event sources
  // These signals are common to all pairs: the core-clock running level,
  // the privilege level, the late-field check and the extended write data.
  // Writes with a late field set are refused whole, so the selector
  // never holds a half-applied value.
  logic core_running;
  logic priv_kernel;
  logic wr_late_field;
  logic [63:0] sext_wdata;
  logic [31:0] sel_wmask;

  // Core clock counts stop in sleep, halt, stop-clock, throttle, switching
  assign core_running = !(event_i.sleep || event_i.halt || stop_clock_active ||
                          event_i.thermal_throttle || event_i.freq_switch);
  assign priv_kernel = (cpl_i == 2'b00);
  // Field added after the first version, never supported here
  assign wr_late_field = req_i.wdata[APC_LATE_BIT] ||
                         (!PIN_SUPPORTED && req_i.wdata[APC_PIN_BIT]);
  // Low 32 bits written, upper bits copy bit 31
  assign sext_wdata = {{32{req_i.wdata[31]}}, req_i.wdata[31:0]};
  // Unsupported pin bit stays reserved and reads zero
  assign sel_wmask = PIN_SUPPORTED ? ~(32'h1 << APC_LATE_BIT) :
                     ~((32'h1 << APC_LATE_BIT) | (32'h1 << APC_PIN_BIT));

  logic [31:0] selector [NUM_CTR];
  logic [CTR_WIDTH-1:0] counter [NUM_CTR];
  logic [NUM_CTR-1:0] hit_ctr;
  logic [NUM_CTR-1:0] hit_sel;

  // ==================================================
  // Per-counter pair; state is private to this logical processor
  // Each pair decodes its own two addresses, forms a per-cycle condition
  // from event code, qualifier, privilege, threshold and invert bit, and
  // adds the resulting amount to its counter while enabled.
  // A counter write in the same cycle as an increment wins; software is
  // expected to disable the pair first, so no increment is lost then.
  genvar g;
  generate
    for (g = 0; g < NUM_CTR; g++) begin : g_pair
      logic [7:0] ev_code;
      logic [7:0] qual;
      logic [7:0] thresh;
      logic [2:0] raw_count;
      logic priv_ok;
      logic cond;
      logic prev_cond;
      logic [CTR_WIDTH-1:0] incr;
      logic [CTR_WIDTH:0] sum;
      logic overflow;
      logic pin_pending;
      logic [1:0] pin_hold;

      assign hit_ctr[g] = (req_i.addr == APC_COUNTER_BASE + 32'(g));
      assign hit_sel[g] = (req_i.addr == APC_SELECTOR_BASE + 32'(g));
      assign ev_code = selector[g][APC_EVSEL_LSB +: 8];
      assign qual = selector[g][APC_QUAL_LSB +: 8];
      assign thresh = selector[g][APC_THRESH_LSB +: 8];

      // Event source by code and qualifier
      always_comb begin
        raw_count = 3'h0;
        if (qual == APC_QUAL_DEFAULT) begin
          unique case (ev_code)
            APC_EV_CORE_CYCLES: raw_count = {2'b00, core_running};
            APC_EV_INSTR_RETIRED: raw_count = event_i.instr_count;
            APC_EV_BRANCH_RETIRED: raw_count = event_i.branch_count;
            APC_EV_BRANCH_MISS: raw_count = event_i.miss_count;
            default: raw_count = 3'h0;
          endcase
        end
      end

      // Privilege filter
      assign priv_ok = (selector[g][APC_USER_BIT] && !priv_kernel) ||
                       (selector[g][APC_KERNEL_BIT] && priv_kernel);

      // Threshold compare, invert ignored at zero threshold
      always_comb begin
        if (thresh == 8'h00) begin
          cond = priv_ok && (raw_count != 3'h0);
        end else if (selector[g][APC_INV_BIT]) begin
          cond = priv_ok && ({5'h00, raw_count} < thresh);
        end else begin
          cond = priv_ok && ({5'h00, raw_count} >= thresh);
        end
      end

      // Increment amount
      always_comb begin
        if (selector[g][APC_EDGE_BIT]) begin
          incr = CTR_WIDTH'(cond && !prev_cond);
        end else if (thresh != 8'h00) begin
          incr = CTR_WIDTH'(cond);
        end else begin
          incr = priv_ok ? CTR_WIDTH'(raw_count) : '0;
        end
      end

      assign sum = {1'b0, counter[g]} + {1'b0, incr};
      assign overflow = selector[g][APC_ENABLE_BIT] && sum[CTR_WIDTH];

      // Previous condition for edge detection
      // Held while disabled, so re-enabling does not invent a rising edge
      // from a condition that stood all along.
      always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          prev_cond <= 1'b0;
        end else if (selector[g][APC_ENABLE_BIT]) begin
          prev_cond <= cond;
        end
      end

      // Selector register
      always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          selector[g] <= APC_SELECTOR_RESET;
        end else if (req_i.wr && hit_sel[g] && !wr_late_field) begin
          selector[g] <= req_i.wdata[31:0] & sel_wmask;
        end
      end

      // Counter: write wins, else count when enabled
      always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          counter[g] <= '0;
        end else if (req_i.wr && hit_ctr[g]) begin
          counter[g] <= sext_wdata[CTR_WIDTH-1:0];
        end else if (selector[g][APC_ENABLE_BIT]) begin
          counter[g] <= sum[CTR_WIDTH-1:0];
        end
      end

      // Overflow interrupt request, one cycle
      always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          overflow_irq_o[g] <= 1'b0;
        end else begin
          overflow_irq_o[g] <= overflow && selector[g][APC_INT_BIT];
        end
      end

      // Monitor pin: one bus clock assertion per event or overflow
      // pin_hold walks idle, high, low so that two pulses are always
      // separated by at least one low bus period. Triggers arriving during
      // a pulse merge into one pending request; a trigger wins over the
      // clear when both fall in one cycle.
      always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          pin_pending <= 1'b0;
          pin_hold <= 2'b00;
          monitor_pins_o[g] <= 1'b0;
        end else begin
          if (selector[g][APC_PIN_BIT] ? (selector[g][APC_ENABLE_BIT] && incr != '0) : overflow) begin
            pin_pending <= 1'b1;
          end else if (bus_tick && pin_hold == 2'b00) begin
            pin_pending <= 1'b0;
          end
          if (bus_tick) begin
            if (pin_hold == 2'b01) begin
              pin_hold <= 2'b10;
              monitor_pins_o[g] <= 1'b0;
            end else if (pin_pending && pin_hold == 2'b00) begin
              pin_hold <= 2'b01;
              monitor_pins_o[g] <= 1'b1;
            end else begin
              pin_hold <= 2'b00;
              monitor_pins_o[g] <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

  // ==================================================
  // Register read mux
  // Counter values are zero-extended to 64 bits; only CTR_WIDTH bits are
  // meaningful, as the capability word reports.
  // Unmapped addresses select nothing and raise a fault instead.
  logic [63:0] next_rdata;
  logic any_hit;

  always_comb begin
    next_rdata = 64'h0;
    for (int i = 0; i < NUM_CTR; i++) begin
      if (hit_ctr[i]) begin
        next_rdata = 64'(counter[i]);
      end
      if (hit_sel[i]) begin
        next_rdata = {32'h0, selector[i]};
      end
    end
  end

  assign any_hit = (|hit_ctr) || (|hit_sel);

  // Read data and valid, one cycle after request
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 64'h0;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd && any_hit;
      if (req_i.rd && any_hit) begin
        rdata_o <= next_rdata;
      end
    end
  end

  // Fault on unmapped address or unsupported field write
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      protection_fault_o <= 1'b0;
    end else begin
      protection_fault_o <= ((req_i.rd || req_i.wr) && !any_hit) ||
                            (req_i.wr && (|hit_sel) && wr_late_field);
    end
  end

  // ==================================================
  // Capability query answer
  // Words stay zero until the first query, then hold until the next one.
  // The first word packs event count, counter width, counter count and
  // version; the second marks the predefined events that are missing.
  // The version is above zero, so the facility reads as present.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cap_eax_o <= 32'h0;
      cap_ebx_o <= 32'h0;
    end else if (query_i) begin
      cap_eax_o <= {APC_NUM_ARCH_EVENTS, 8'(CTR_WIDTH), 8'(NUM_CTR), APC_VERSION};
      cap_ebx_o <= APC_UNAVAIL_MASK;
    end
  end

endmodule // apc_counters

// >>> testbench/apc_counters_props.sv
`timescale 1ns/1ps
module apc_props
  import apc_pkg::*;
#(
  parameter int NUM_CTR = 4,
  parameter int CTR_WIDTH = 48
) (
  // Clock, reset and register port
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire apc_pkg::apc_req_type req_i,
  input wire logic [63:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic protection_fault_o,
  // Capability and counter outputs
  input wire logic query_i,
  input wire logic [31:0] cap_eax_o,
  input wire logic [31:0] cap_ebx_o,
  input wire logic [NUM_CTR-1:0] monitor_pins_o,
  input wire logic [NUM_CTR-1:0] overflow_irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // ==================================================
  // Address decode helpers
  logic ctr_hit;
  logic sel_hit;
  assign ctr_hit = (req_i.addr - APC_COUNTER_BASE) < 32'(NUM_CTR);
  assign sel_hit = (req_i.addr - APC_SELECTOR_BASE) < 32'(NUM_CTR);
  // Pin pulse of one bus period
  sequence s_pin_pulse;
    monitor_pins_o[0] [*4] ##1 !monitor_pins_o[0];
  endsequence
  // ==================================================
  // Properties
  a_read_answer:
    assert property (req_i.rd && (ctr_hit || sel_hit) |=> rvalid_o && !protection_fault_o) else $error("read lost");
  a_unmapped_fault:
    assert property ((req_i.rd || req_i.wr) && !ctr_hit && !sel_hit |=> protection_fault_o && !rvalid_o)
    else $error("unmapped not faulted");
  a_ctr_write_ok:
    assert property (req_i.wr && ctr_hit |=> !protection_fault_o) else $error("counter write faulted");
  a_late_field:
    assert property (req_i.wr && sel_hit && req_i.wdata[21] |=> protection_fault_o) else $error("bit21 accepted");
  a_cap_layout:
    assert property (query_i |=> cap_eax_o == {APC_NUM_ARCH_EVENTS, 8'(CTR_WIDTH), 8'(NUM_CTR), APC_VERSION})
    else $error("capability word wrong");
  a_cap_mask:
    assert property (query_i |=> cap_ebx_o == APC_UNAVAIL_MASK) else $error("unavailable mask wrong");
  a_rdata_hold:
    assert property (!rvalid_o |-> $stable(rdata_o)) else $error("read data moved");
  a_rvalid_cause:
    assert property (rvalid_o |-> $past(req_i.rd)) else $error("answer without read");
  a_irq_pulse:
    assert property (overflow_irq_o[0] |=> !overflow_irq_o[0]) else $error("irq too long");
  a_pin_width:
    assert property ($rose(monitor_pins_o[0]) |-> s_pin_pulse) else $error("pin pulse width");
endmodule // apc_props

bind apc_counters apc_props #(.NUM_CTR(NUM_CTR), .CTR_WIDTH(CTR_WIDTH)) u_props (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .req_i(req_i), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o), .protection_fault_o(protection_fault_o), .query_i(query_i),
  .cap_eax_o(cap_eax_o), .cap_ebx_o(cap_ebx_o), .monitor_pins_o(monitor_pins_o),
  .overflow_irq_o(overflow_irq_o));

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import apc_pkg::*;
  typedef struct packed {logic [31:0] sel; logic [1:0] cpl; logic halt_instruction; logic [7:0] exp;} apc_case_type;
  logic sys_clk_i, resetn_i, query_i, stop_clock_pin_i;
  logic [1:0] cpl_i;
  apc_req_type req_i;
  apc_event_type event_i;
  logic [63:0] rdata_o;
  logic rvalid_o, protection_fault_o;
  logic [31:0] cap_eax_o, cap_ebx_o;
  logic [3:0] monitor_pins_o, overflow_irq_o;
  int mismatches, n_checks;
  // Selector, cpl, halt, expected total over five counting edges
  apc_case_type cases [15] = '{
    '{32'h0006_003c, 2'd0, 1'b0, 8'd1}, '{32'h0002_003c, 2'd0, 1'b0, 8'd5},
    '{32'h0002_003c, 2'd0, 1'b1, 8'd0}, '{32'h0002_00c0, 2'd0, 1'b0, 8'd10},
    '{32'h0002_00c4, 2'd0, 1'b0, 8'd5}, '{32'h0002_00c5, 2'd0, 1'b0, 8'd15},
    '{32'h0002_002e, 2'd0, 1'b0, 8'd0}, '{32'h0002_013c, 2'd0, 1'b0, 8'd0},
    '{32'h0002_003c, 2'd3, 1'b0, 8'd0}, '{32'h0001_003c, 2'd3, 1'b0, 8'd5},
    '{32'h0003_003c, 2'd0, 1'b0, 8'd5}, '{32'h0202_00c0, 2'd0, 1'b0, 8'd5},
    '{32'h0302_00c0, 2'd0, 1'b0, 8'd0}, '{32'h0382_00c0, 2'd0, 1'b0, 8'd5},
    '{32'h0082_00c0, 2'd0, 1'b0, 8'd10}};

  apc_counters #(.NUM_CTR(4), .CTR_WIDTH(48)) dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .protection_fault_o(protection_fault_o),
    .query_i(query_i), .cap_eax_o(cap_eax_o), .cap_ebx_o(cap_ebx_o), .cpl_i(cpl_i), .event_i(event_i),
    .stop_clock_pin_i(stop_clock_pin_i), .monitor_pins_o(monitor_pins_o), .overflow_irq_o(overflow_irq_o));

  // ==================================================
  // Clock
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // ==================================================
  // Access tasks
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic acc(input logic r, input logic w, input logic [31:0] a, input logic [63:0] d);
    @(posedge sys_clk_i);
    req_i <= '{rd: r, wr: w, addr: a, wdata: d};
    @(posedge sys_clk_i);
    req_i.rd <= 1'b0;
    req_i.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [31:0] a, input logic [63:0] e);
    acc(1'b1, 1'b0, a, 64'h0);
    chk(rdata_o, e);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Bounded wait for overflow irq or monitor pin
  task automatic await(input logic pin);
    int k;
    k = 0;
    while (k < 40 && (pin ? monitor_pins_o[0] : overflow_irq_o[0]) !== 1'b1) begin
      @(posedge sys_clk_i);
      #1;
      k++;
    end
    chk(64'(k < 40), 64'h1);
    if (k == 40)
      close_out;
  endtask

  // Clear counter, count five edges, stop, read back
  task automatic run(input apc_case_type c);
    @(posedge sys_clk_i);
    cpl_i <= c.cpl;
    event_i.halt <= c.halt_instruction;
    acc(1'b0, 1'b1, APC_COUNTER_BASE, 64'h0);
    acc(1'b0, 1'b1, APC_SELECTOR_BASE, 64'(c.sel | 32'h0040_0000));
    repeat (3) @(posedge sys_clk_i);
    acc(1'b0, 1'b1, APC_SELECTOR_BASE, 64'(c.sel));
    repeat (2) @(posedge sys_clk_i);
    rd(APC_COUNTER_BASE, 64'(c.exp));
  endtask

  // ==================================================
  // Main sequence
  initial begin
    resetn_i = 1'b0;
    req_i = '0;
    query_i = 1'b0;
    cpl_i = 2'd0;
    stop_clock_pin_i = 1'b0;
    event_i = '{instr_count: 3'd2, branch_count: 3'd1, miss_count: 3'd3, default: 1'b0};
    mismatches = 0;
    n_checks = 0;
    repeat (16) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    rd(APC_SELECTOR_BASE, 64'h0);
    @(posedge sys_clk_i);
    query_i <= 1'b1;
    @(posedge sys_clk_i);
    query_i <= 1'b0;
    #1;
    chk(64'(cap_eax_o), 64'({APC_NUM_ARCH_EVENTS, 8'd48, 8'd4, APC_VERSION}));
    chk(64'(cap_ebx_o), 64'(APC_UNAVAIL_MASK));
    acc(1'b1, 1'b0, 32'h0000_00c5, 64'h0);
    chk(64'(protection_fault_o), 64'h1);
    acc(1'b0, 1'b1, 32'h0000_018a, 64'h0);
    chk(64'(protection_fault_o), 64'h1);
    acc(1'b0, 1'b1, 32'h0000_0187, 64'h0020_0000);
    chk(64'(protection_fault_o), 64'h1);
    rd(32'h0000_0187, 64'h0);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 1'b1, APC_SELECTOR_BASE + i, 64'(32'h0001_0000 + i));
      acc(1'b0, 1'b1, APC_COUNTER_BASE + i, 64'(i + 5));
    end
    for (int i = 0; i < 4; i++) begin
      rd(APC_SELECTOR_BASE + i, 64'(32'h0001_0000 + i));
      rd(APC_COUNTER_BASE + i, 64'(i + 5));
    end
    acc(1'b0, 1'b1, 32'h0000_00c2, 64'h1234_5678_8000_0001);
    rd(32'h0000_00c2, 64'h0000_ffff_8000_0001);
    acc(1'b0, 1'b1, 32'h0000_00c2, 64'hffff_ffff_7fff_ffff);
    rd(32'h0000_00c2, 64'h0000_0000_7fff_ffff);
    foreach (cases[k]) run(cases[k]);
    acc(1'b0, 1'b1, APC_COUNTER_BASE, 64'hffff_fffe);
    acc(1'b0, 1'b1, APC_SELECTOR_BASE, 64'h0052_003c);
    await(1'b0);
    await(1'b1);
    acc(1'b0, 1'b1, APC_SELECTOR_BASE, 64'h0002_003c);
    acc(1'b1, 1'b0, APC_COUNTER_BASE, 64'h0);
    chk(64'(rdata_o[47:8]), 64'h0);
    acc(1'b0, 1'b1, APC_SELECTOR_BASE, 64'h004a_00c4);
    await(1'b1);
    close_out;
  end
endmodule // testbench
